/* File: rtl/sleep_alarm_pkg.sv */
/*
 * Shared constants and types of the backup sleep, wakeup and alarm block:
 * register byte offsets, field positions, reset values, dividers and the
 * packed carriers for the control byte, the interrupt events and the bus
 * request. Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
package sleep_alarm_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] RTC_SEL_OFS = 8'h80;
  localparam logic [7:0] CTRL_OFS = 8'h84;
  localparam logic [7:0] STATUS_OFS = 8'h88;
  localparam logic [7:0] WORD_FIRST_OFS = 8'h90;
  localparam logic [7:0] WORD_LAST_OFS = 8'hac;
  localparam logic [7:0] IRQ_STAT_OFS = 8'hb0;
  localparam logic [7:0] IRQ_MASK_OFS = 8'hb4;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTRL_FLAGS_LSB = 24;
  localparam int WAKE_CLEAR_BIT = 31;
  localparam int CAUSE_BIT = 24;
  localparam int SRC_SEL_LSB = 2;
  localparam int CNT_W = 24;
  localparam int WORDS = 8;
  localparam logic [23:0] ALARM_RESET = 24'h01ffff;
  localparam logic [23:0] COUNT_RESET = 24'h000000;
  localparam logic [31:0] WORD_RESET = 32'h00000000;

  // ****************************************
  // Dividers of the backup time base
  // ****************************************
  localparam int HSE_DIV = 128;
  localparam int MIN_SECS = 60;
  localparam int SEC_TICKS_DEF = 32768;

  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_LSE = 2'h1,
    SRC_LSI = 2'h2,
    SRC_HSE = 2'h3
  } rtc_src_t;

  // Upper byte of the sleep control register, bit 31 first
  typedef struct packed {
    logic wake_flag_clear;
    logic sleep_all_sources_off;
    logic sleep_regulator_low_power;
    logic sleep_regulator_off;
    logic pin_wake_enable;
    logic sleep_counter_enable;
    logic sleep_alarm_enable;
    logic alarm_unit_select;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 8'h00;

  // Sticky interrupt events, bit 2 first
  typedef struct packed {
    logic pin;
    logic resume;
    logic alarm;
  } evt_t;

  localparam int EVT_W = 3;

  typedef struct packed {
    logic [7:0] adr;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

endpackage : sleep_alarm_pkg

/* File: rtl/tick_div.sv */
/*
 * Enable divider: one output pulse per DIV input enable pulses.
 * Assumes en_i is a one-cycle pulse synchronous to clk_i.
 */
`timescale 1ns/10ps
module tick_div #(
  parameter int DIV = 128
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Enables
  input wire logic en_i,
  output logic tick_o
);

  localparam int W = $clog2(DIV + 1);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= en_i && (cnt_q == LAST);
      if (en_i) begin
        cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + W'(1);
      end
    end
  end

endmodule : tick_div

/* File: rtl/retained_words.sv */
/*
 * Eight retained 32-bit words with byte-lane writes and registered read
 * data. Assumes the caller presents the read index one cycle early.
 */
`timescale 1ns/10ps
module retained_words #(
  parameter int N = sleep_alarm_pkg::WORDS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Access
  input wire logic we_i,
  input wire logic [3:0] be_i,
  input wire logic [$clog2(N)-1:0] wr_idx_i,
  input wire logic [$clog2(N)-1:0] rd_idx_i,
  input wire logic [31:0] wdat_i,
  output logic [31:0] rdat_o
);

  import sleep_alarm_pkg::*;

  logic [31:0] mem_q [N];

  // Contents only clear on the backup-domain reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N; i++) begin
        mem_q[i] <= WORD_RESET;
      end
    end else if (we_i) begin
      for (int b = 0; b < 4; b++) begin
        if (be_i[b]) begin
          mem_q[wr_idx_i][8*b +: 8] <= wdat_i[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_o <= WORD_RESET;
    end else begin
      rdat_o <= mem_q[rd_idx_i];
    end
  end

endmodule : retained_words

/* File: rtl/backup_sleep_wakeup_alarm.sv */
/*
 * Backup-domain sleep controller: deep-sleep power and clock options,
 * pin wakeup gate, sleep counter with alarm, wake flags and retained
 * words, all behind a classic Wishbone slave.
 * Assumes every input is synchronous to clk_i and the tick inputs are
 * one-cycle pulses, one per period of each oscillator.
 */
// Added by the designer: register access over Wishbone.
// Summary of operation
// - Resume from low power sets clear-wakeup bit
// - Writing one clears both wake flags
// - Deep sleep with sources-off stops all clocks
// - Regulator low power during deep sleep
// - Regulator off during deep sleep
// - Pin wakes only when enabled
// - Counter advances only while enabled
// - Alarm events only while alarm enabled
// - Unit bit picks seconds or minutes
// - Alarm value write-only, reset 0x1FFFF
// - Cause flag: zero alarm, one low-power
// - Status shows counter, reserved bits zero
// - Eight retained words at 0x90-0xAC
// - Two-bit source select of counter clock
`timescale 1ns/10ps
module backup_sleep_wakeup_alarm
  import sleep_alarm_pkg::*;
#(
  parameter int SEC_TICKS = SEC_TICKS_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Power manager and oscillators
  input wire logic deep_sleep_i,
  input wire logic lowpower_resume_i,
  input wire logic wake_pin_i,
  input wire logic lse_tick_i,
  input wire logic lsi_tick_i,
  input wire logic hse_tick_i,
  // Power controls and events
  output logic clocks_off_o,
  output logic regulator_low_power_o,
  output logic regulator_off_o,
  output logic wake_request_o,
  output logic irq_o
);

  import sleep_alarm_pkg::*;

  typedef enum logic [1:0] {BUS_IDLE, BUS_FETCH, BUS_ACK} bus_t;

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    return (old & ~lane_mask(sel)) | (nw & lane_mask(sel));
  endfunction : merge

  // ****************************************
  // Bus slave
  // ****************************************
  bus_t state_q;
  wb_req_t req_q;
  logic [31:0] word_rdat;
  logic fetch;
  logic word_hit;

  assign fetch = (state_q == BUS_FETCH);
  assign word_hit = (req_q.adr >= WORD_FIRST_OFS) && (req_q.adr <= WORD_LAST_OFS) &&
                    (req_q.adr[1:0] == 2'h0);

  // Two-cycle answer so the retained words can come out of a register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= BUS_IDLE;
      req_q <= '0;
      ack_o <= 1'b0;
    end else begin
      ack_o <= fetch;
      case (state_q)
        BUS_IDLE: begin
          if (cyc_i && stb_i) begin
            state_q <= BUS_FETCH;
            req_q <= '{adr: adr_i, we: we_i, sel: sel_i, dat: dat_i};
          end
        end
        BUS_FETCH: state_q <= BUS_ACK;
        BUS_ACK: state_q <= BUS_IDLE;
        default: state_q <= BUS_IDLE;
      endcase
    end
  end

  function automatic logic wr_at(input logic [7:0] ofs, input logic f, input wb_req_t r);
    return f && r.we && (r.adr == ofs);
  endfunction : wr_at

  retained_words #(.N(WORDS)) u_words (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(fetch && req_q.we && word_hit),
    .be_i(req_q.sel),
    .wr_idx_i(req_q.adr[4:2]),
    .rd_idx_i(adr_i[4:2]),
    .wdat_i(req_q.dat),
    .rdat_o(word_rdat)
  );

  // ****************************************
  // Control and source registers
  // ****************************************
  ctrl_t ctrl_q;
  logic [23:0] alarm_q;
  logic [1:0] src_q;
  logic [31:0] ctrl_new;
  logic [31:0] src_new;
  logic clear_wr;

  // Unselected lanes keep the alarm value, so a flag-only write cannot zero it
  assign ctrl_new = merge({ctrl_q, alarm_q}, req_q.dat, req_q.sel);
  assign src_new = merge({28'h0, src_q, 2'h0}, req_q.dat, req_q.sel);
  assign clear_wr = wr_at(CTRL_OFS, fetch, req_q) && req_q.sel[3] &&
                    req_q.dat[WAKE_CLEAR_BIT];

  // Option bits are plain read/write; a resume beats a clear of the top bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET;
      alarm_q <= ALARM_RESET;
      src_q <= SRC_NONE;
    end else begin
      if (wr_at(CTRL_OFS, fetch, req_q)) begin
        ctrl_q[6:0] <= ctrl_new[CTRL_FLAGS_LSB +: 7];
        alarm_q <= ctrl_new[23:0];
      end
      if (lowpower_resume_i) begin
        ctrl_q.wake_flag_clear <= 1'b1;
      end else if (clear_wr) begin
        ctrl_q.wake_flag_clear <= 1'b0;
      end
      if (wr_at(RTC_SEL_OFS, fetch, req_q)) begin
        src_q <= src_new[SRC_SEL_LSB +: 2];
      end
    end
  end

  // ****************************************
  // Time base and sleep counter
  // ****************************************
  logic hse_tick;
  logic rtc_tick;
  logic sec_tick;
  logic min_tick;
  logic unit_tick;
  logic [23:0] count_q;
  logic [23:0] count_next;
  logic alarm_fire;

  tick_div #(.DIV(HSE_DIV)) u_hse_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(hse_tick_i),
    .tick_o(hse_tick)
  );

  always_comb begin
    case (rtc_src_t'(src_q))
      SRC_LSE: rtc_tick = lse_tick_i;
      SRC_LSI: rtc_tick = lsi_tick_i;
      SRC_HSE: rtc_tick = hse_tick;
      default: rtc_tick = 1'b0;
    endcase
  end

  tick_div #(.DIV(SEC_TICKS)) u_sec_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(rtc_tick),
    .tick_o(sec_tick)
  );

  tick_div #(.DIV(MIN_SECS)) u_min_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(sec_tick),
    .tick_o(min_tick)
  );

  assign unit_tick = ctrl_q.alarm_unit_select ? min_tick : sec_tick;
  assign count_next = count_q + 24'h000001;
  assign alarm_fire = ctrl_q.sleep_counter_enable && ctrl_q.sleep_alarm_enable &&
                      unit_tick && (count_next == alarm_q);

  // Counter wraps at the top; it is only cleared by the backup reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= COUNT_RESET;
    end else if (ctrl_q.sleep_counter_enable && unit_tick) begin
      count_q <= count_next;
    end
  end

  // ****************************************
  // Wakeup flags and requests
  // ****************************************
  logic cause_q;
  logic pin_q;
  logic pin_fire;

  assign pin_fire = ctrl_q.pin_wake_enable && deep_sleep_i && wake_pin_i && !pin_q;

  // A resume in the same cycle as a clear wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_q <= 1'b0;
    end else begin
      if (lowpower_resume_i) begin
        cause_q <= 1'b1;
      end else if (alarm_fire || clear_wr) begin
        cause_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= 1'b0;
      wake_request_o <= 1'b0;
    end else begin
      pin_q <= wake_pin_i;
      wake_request_o <= alarm_fire || pin_fire;
    end
  end

  // ****************************************
  // Deep-sleep power controls
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clocks_off_o <= 1'b0;
      regulator_low_power_o <= 1'b0;
      regulator_off_o <= 1'b0;
    end else begin
      clocks_off_o <= deep_sleep_i && ctrl_q.sleep_all_sources_off;
      // Removing the supply overrides the low-power request
      regulator_low_power_o <= deep_sleep_i && ctrl_q.sleep_regulator_low_power &&
                               !ctrl_q.sleep_regulator_off;
      regulator_off_o <= deep_sleep_i && ctrl_q.sleep_regulator_off;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  evt_t irq_stat_q;
  evt_t irq_mask_q;
  evt_t evt;
  evt_t irq_clr;
  logic [31:0] mask_new;

  assign evt = '{pin: pin_fire, resume: lowpower_resume_i, alarm: alarm_fire};
  assign irq_clr = wr_at(IRQ_STAT_OFS, fetch, req_q) ?
                   evt_t'(req_q.dat[EVT_W-1:0] & {EVT_W{req_q.sel[0]}}) : '0;
  assign mask_new = merge({29'h0, irq_mask_q}, req_q.dat, req_q.sel);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | evt;
      if (wr_at(IRQ_MASK_OFS, fetch, req_q)) begin
        irq_mask_q <= mask_new[EVT_W-1:0];
      end
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (fetch) begin
      if (req_q.we) begin
        dat_o <= '0;
      end else if (word_hit) begin
        dat_o <= word_rdat;
      end else begin
        case (req_q.adr)
          CTRL_OFS: dat_o <= {ctrl_q, 24'h0};
          STATUS_OFS: dat_o <= {7'h0, cause_q, count_q};
          RTC_SEL_OFS: dat_o <= {28'h0, src_q, 2'h0};
          IRQ_STAT_OFS: dat_o <= {29'h0, irq_stat_q};
          IRQ_MASK_OFS: dat_o <= {29'h0, irq_mask_q};
          default: dat_o <= '0;
        endcase
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_resume;
    lowpower_resume_i;
  endsequence

  sequence s_flag_set;
    ctrl_q.wake_flag_clear && cause_q;
  endsequence

  a_resume_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    s_resume |=> s_flag_set) else $error("resume did not set wake flags");

  a_clear_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_wr && !lowpower_resume_i |=> !ctrl_q.wake_flag_clear && !cause_q)
    else $error("clear write left a wake flag");

  a_clocks_off: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 clocks_off_o == $past(deep_sleep_i && ctrl_q.sleep_all_sources_off))
    else $error("clock-off output wrong");

  a_reg_low: assert property (@(posedge clk_i) disable iff (rst_i)
    regulator_low_power_o |-> !regulator_off_o && $past(deep_sleep_i))
    else $error("regulator low power outside deep sleep");

  a_reg_off: assert property (@(posedge clk_i) disable iff (rst_i)
    deep_sleep_i && ctrl_q.sleep_regulator_off |=> regulator_off_o)
    else $error("regulator not removed in deep sleep");

  a_pin_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_q.pin_wake_enable && !alarm_fire |=> !wake_request_o)
    else $error("wake request without enabled source");

  a_count_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_q.sleep_counter_enable |=> $stable(count_q))
    else $error("counter moved while disabled");

  a_alarm_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_q.sleep_alarm_enable |-> !alarm_fire) else $error("alarm while disabled");

  a_alarm_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    fetch && !req_q.we && req_q.adr == CTRL_OFS |=> dat_o[23:0] == 24'h0 && ack_o)
    else $error("alarm value read back");

  a_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
    fetch && !req_q.we && req_q.adr == STATUS_OFS
    |=> dat_o == {7'h0, $past(cause_q), $past(count_q)}) else $error("status read wrong");

  a_alarm_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    alarm_fire && !lowpower_resume_i |=> wake_request_o && !cause_q && count_q == $past(alarm_q))
    else $error("alarm match without wake");

endmodule : backup_sleep_wakeup_alarm

/* File: testbench/tb_top.sv */
/*
 * Self-checking bench of the backup sleep, wakeup and alarm block.
 * Assumes the package and the design files are compiled before it.
 */
`timescale 1ns/10ps
module tb_top;
  import sleep_alarm_pkg::*;
  // ****************************************
  // Signals and model state
  // ****************************************
  localparam int TPS = 4;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic ack_o, deep_sleep_i = 1'b0, lowpower_resume_i = 1'b0, wake_pin_i = 1'b0;
  logic lse_tick_i = 1'b0, lsi_tick_i = 1'b0, hse_tick_i = 1'b0;
  logic clocks_off_o, regulator_low_power_o, regulator_off_o, wake_request_o, irq_o;
  int errors = 0, total_checks = 0, wakes = 0, w0;
  int unsigned cnt = 0, v;
  logic [31:0] words [WORDS];

  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (wake_request_o === 1'b1) wakes <= wakes + 1;

  backup_sleep_wakeup_alarm #(.SEC_TICKS(TPS)) backup_sleep_wakeup_alarm_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .deep_sleep_i(deep_sleep_i), .lowpower_resume_i(lowpower_resume_i),
    .wake_pin_i(wake_pin_i), .lse_tick_i(lse_tick_i), .lsi_tick_i(lsi_tick_i),
    .hse_tick_i(hse_tick_i), .clocks_off_o(clocks_off_o),
    .regulator_low_power_o(regulator_low_power_o), .regulator_off_o(regulator_off_o),
    .wake_request_o(wake_request_o), .irq_o(irq_o));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Entered just after a rising edge; ack and read data are taken at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) chk("ack", 32'h1, 32'h0);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    wb(1'b0, a, 4'hf, 32'h0);
    chk(what, exp & m, rd & m);
  endtask : rdchk

  // Tick pulses on the chosen oscillators; the tail covers the divider stages
  task automatic ticks(input int n, input logic [2:0] m);
    repeat (n) begin
      {hse_tick_i, lsi_tick_i, lse_tick_i} <= m;
      @(posedge clk_i);
      {hse_tick_i, lsi_tick_i, lse_tick_i} <= 3'b000;
      @(posedge clk_i);
    end
    repeat (6) @(posedge clk_i);
  endtask : ticks

  task automatic resume();
    lowpower_resume_i <= 1'b1;
    @(posedge clk_i);
    lowpower_resume_i <= 1'b0;
    @(posedge clk_i);
  endtask : resume

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    #(50 * 60000);
    errors++;
    conclude();
  end

  initial begin
    v = $urandom(32'h3397);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < WORDS; i++)
      rdchk("word", WORD_FIRST_OFS + 8'(4 * i), '1, WORD_RESET);
    rdchk("status", STATUS_OFS, '1, 32'h0);
    rdchk("ctrl", CTRL_OFS, '1, 32'h0);
    rdchk("unmapped", 8'h8c, '1, 32'h0);
    $display("test reset done");

    for (int i = 0; i < WORDS; i++) begin
      words[i] = $urandom();
      wb(1'b1, WORD_FIRST_OFS + 8'(4 * i), 4'hf, words[i]);
    end
    // Only lanes 0 and 2 are enabled, so the other two bytes must survive
    wb(1'b1, WORD_FIRST_OFS + 8'h04, 4'h5, 32'h0);
    words[1] = words[1] & 32'hff00ff00;
    for (int i = 0; i < WORDS; i++)
      rdchk("word", WORD_FIRST_OFS + 8'(4 * i), '1, words[i]);
    $display("test words done");

    // Every source gets 512 ticks on all three lines, so only the chosen one counts
    wb(1'b1, CTRL_OFS, 4'hf, 32'h04000000);
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, RTC_SEL_OFS, 4'hf, 32'(s) << SRC_SEL_LSB);
      ticks(512, 3'b001);
      ticks(512, 3'b010);
      ticks(512, 3'b100);
      cnt += (s == 0) ? 0 : (s == 3) ? 512 / (HSE_DIV * TPS) : 512 / TPS;
      rdchk("count", STATUS_OFS, 32'h00ffffff, cnt);
    end
    // Back to the low-speed internal source, so the ticks below do reach the dividers
    wb(1'b1, RTC_SEL_OFS, 4'hf, 32'(SRC_LSI) << SRC_SEL_LSB);
    wb(1'b1, CTRL_OFS, 4'hf, 32'h0);
    ticks(8, 3'b010);
    rdchk("held count", STATUS_OFS, '1, cnt);
    // One minute of ticks crosses exactly one minute boundary whatever the phase
    wb(1'b1, CTRL_OFS, 4'hf, 32'h05000000);
    ticks(MIN_SECS * TPS, 3'b010);
    cnt += 1;
    rdchk("minute count", STATUS_OFS, '1, cnt);
    $display("test counter done");

    resume();
    rdchk("ctrl wake", CTRL_OFS, 32'h80000000, 32'h80000000);
    rdchk("cause", STATUS_OFS, 32'h01000000, 32'h01000000);
    rdchk("irq status", IRQ_STAT_OFS, 32'h7, 32'h2);
    wb(1'b1, IRQ_STAT_OFS, 4'h1, 32'h2);
    wb(1'b1, IRQ_MASK_OFS, 4'hf, 32'h1);
    @(negedge clk_i);
    chk("irq idle", 32'h0, irq_o);
    @(posedge clk_i);
    w0 = wakes;
    wb(1'b1, CTRL_OFS, 4'hf, 32'h06000000 | (cnt + 2));
    ticks(3 * TPS, 3'b010);
    cnt += 3;
    chk("alarm wakes", 32'h1, wakes - w0);
    rdchk("status alarm", STATUS_OFS, '1, cnt);
    @(negedge clk_i);
    chk("irq alarm", 32'h1, irq_o);
    @(posedge clk_i);
    rdchk("irq status", IRQ_STAT_OFS, 32'h7, 32'h1);
    wb(1'b1, IRQ_STAT_OFS, 4'h1, 32'h1);
    @(negedge clk_i);
    chk("irq cleared", 32'h0, irq_o);
    @(posedge clk_i);
    w0 = wakes;
    wb(1'b1, CTRL_OFS, 4'hf, 32'h04000000 | (cnt + 1));
    ticks(2 * TPS, 3'b010);
    cnt += 2;
    chk("no alarm", 32'h0, wakes - w0);
    resume();
    wb(1'b1, CTRL_OFS, 4'hf, 32'h80000000);
    rdchk("ctrl cleared", CTRL_OFS, 32'h80000000, 32'h0);
    rdchk("cause cleared", STATUS_OFS, '1, cnt);
    $display("test alarm done");

    for (int m = 0; m < 8; m++) begin
      wb(1'b1, CTRL_OFS, 4'hf, 32'(m) << 28);
      deep_sleep_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chk("clocks off", m[2], clocks_off_o);
      chk("reg low power", m[1] & ~m[0], regulator_low_power_o);
      chk("reg off", m[0], regulator_off_o);
      @(posedge clk_i);
      deep_sleep_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chk("awake", 32'h0, {clocks_off_o, regulator_low_power_o, regulator_off_o});
      @(posedge clk_i);
    end
    for (int m = 0; m < 2; m++) begin
      wb(1'b1, CTRL_OFS, 4'hf, 32'(m) << 27);
      deep_sleep_i <= 1'b1;
      w0 = wakes;
      wake_pin_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      wake_pin_i <= 1'b0;
      deep_sleep_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("pin wakes", 32'(m), wakes - w0);
    end
    // Resume and pin events are still pending from above; the alarm bit was cleared
    rdchk("irq pin", IRQ_STAT_OFS, 32'h7, 32'h6);
    for (int i = 0; i < WORDS; i++)
      rdchk("kept word", WORD_FIRST_OFS + 8'(4 * i), '1, words[i]);
    rdchk("kept count", STATUS_OFS, 32'h00ffffff, cnt);
    $display("test sleep done");

    // Only a backup-domain reset loses the retained state
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk("reset word", WORD_FIRST_OFS + 8'h04, '1, WORD_RESET);
    rdchk("reset status", STATUS_OFS, '1, 32'h0);
    rdchk("reset ctrl", CTRL_OFS, '1, 32'h0);
    rdchk("reset irq", IRQ_STAT_OFS, '1, 32'h0);
    $display("test second reset done");
    conclude();
  end
endmodule : tb_top
